// ---- logic/ros_out_select.sv ----
`timescale 1ns/1ns
module ros_out_select
	import ros_pkg::*;
#(
	parameter ros_pkg::ros_variant_t VARIANT = ros_pkg::ROS_VAR_FULL
)(
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         clkEn,
	input  wire ros_pkg::ros_ahb_req_t        ahbReq,
	input  wire logic [31:0]                  hwdata,
	output ros_pkg::ros_ahb_rsp_t             ahbRsp,
	input  wire logic [ros_pkg::NUM_FUNCS-1:0] periphOut,
	input  wire logic [ros_pkg::NUM_PINS-1:0]  portOut,
	output logic      [ros_pkg::NUM_PINS-1:0]  pinOut,
	output logic      [ros_pkg::NUM_PINS-1:0]  pinRouted
);
	import ros_pkg::*;

	localparam logic [15:0] FIELD_MAP = (VARIANT == ROS_VAR_FULL)     ? FIELDS_FULL :
	                                    (VARIANT == ROS_VAR_SMALL_GP) ? FIELDS_SMALL_GP : FIELDS_SMALL_MC;

	// Writable mask of a register from the variant's field map.
	function automatic logic [15:0] regMask(input int idx);
		regMask = {3'h0, {5{FIELD_MAP[2*idx+1]}}, 3'h0, {5{FIELD_MAP[2*idx]}}};
	endfunction : regMask

	logic [15:0] route [NUM_REGS];
	logic        wrPend;
	logic [2:0]  wrIdx;
	logic        wrHit;
	logic [31:0] rdData;

	wire logic [31:0] wordAddr  = ahbReq.haddr >> 2;
	wire logic [11:0] baseIdx   = OUT_ROUTE_PINS_0_1;
	wire logic [11:0] lastIdx   = OUT_ROUTE_PINS_14_15;
	wire logic        inRange   = (wordAddr[31:12] == 20'h00000) && (wordAddr[11:0] >= baseIdx) &&
	                              (wordAddr[11:0] <= lastIdx) && (wordAddr[0] == 1'b0);
	wire logic [11:0] offIdx    = wordAddr[11:0] - baseIdx;
	wire logic [2:0]  regIdx    = offIdx[3:1];
	wire logic        addrValid = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
	wire logic        mapped    = inRange && (regMask(int'(regIdx)) != 16'h0000);
	wire logic [15:0] selMask   = regMask(int'(regIdx));
	// A read taken in the data phase of a write to the same register sees the new value.
	wire logic        fwdHit    = wrPend && wrHit && (wrIdx == regIdx);
	wire logic [15:0] curWord   = fwdHit ? hwdata[15:0] : route[regIdx];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPend <= 1'b0;
			wrIdx  <= 3'h0;
			wrHit  <= 1'b0;
			rdData <= 32'h00000000;
		end else if (clkEn) begin
			wrPend <= addrValid && ahbReq.hwrite;
			wrIdx  <= regIdx;
			wrHit  <= mapped;
			if (addrValid && !ahbReq.hwrite)
				rdData <= mapped ? {16'h0000, curWord & selMask} : 32'h00000000;
		end
	end

	for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
		localparam logic [15:0] MASK = regMask(r);
		wire logic wrThis = wrPend && wrHit && (wrIdx == 3'(r));
		always_ff @(posedge clk) begin
			if (sys_rst)
				route[r] <= REG_RESET;
			else if (clkEn && wrThis)
				route[r] <= hwdata[15:0] & MASK;
		end
	end

	assign ahbRsp.hrdata    = rdData;
	assign ahbRsp.hreadyout = 1'b1;
	assign ahbRsp.hresp     = 1'b0;

	logic [NUM_PINS*CODE_W-1:0] pinCode;
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_code
		localparam int LSB = (p % 2 == 0) ? EVEN_LSB : ODD_LSB;
		assign pinCode[p*CODE_W +: CODE_W] = route[p/2][LSB +: CODE_W];
	end

	ros_pin_mux u_mux (
		.pinCode   (pinCode),
		.periphOut (periphOut),
		.portOut   (portOut),
		.pinOut    (pinOut),
		.pinRouted (pinRouted)
	);

	a_reset_clears: assert property (
		@(posedge clk) sys_rst |=> (route[0] == REG_RESET && route[7] == REG_RESET))
		else $error("route register not cleared by reset");
	a_reserved_zero: assert property (
		@(posedge clk) disable iff (sys_rst) (rdData[15:13] == 3'h0 && rdData[7:5] == 3'h0))
		else $error("reserved bits read nonzero");
	a_upper_zero: assert property (
		@(posedge clk) disable iff (sys_rst) rdData[31:16] == 16'h0000)
		else $error("upper half reads nonzero");
	a_write_lands: assert property (
		@(posedge clk) disable iff (sys_rst)
		(clkEn && wrPend && wrHit) |=> (route[$past(wrIdx)] == ($past(hwdata[15:0]) & regMask(int'($past(wrIdx))))))
		else $error("write did not land");
	a_odd_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(route[0][12:8] != CODE_PORT) |-> (pinRouted[1] && pinOut[1] == periphOut[route[0][12:8]]))
		else $error("odd pin does not follow its code");
	a_even_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(route[0][4:0] != CODE_PORT) |-> (pinRouted[0] && pinOut[0] == periphOut[route[0][4:0]]))
		else $error("even pin does not follow its code");
	a_absent_reg: assert property (
		@(posedge clk) disable iff (sys_rst) (VARIANT != ROS_VAR_FULL) |-> route[1] == 16'h0000)
		else $error("pins 2/3 register present in small variant");
	a_gp_subset: assert property (
		@(posedge clk) disable iff (sys_rst)
		(VARIANT != ROS_VAR_FULL) |-> (route[2][12:8] == 5'h00 && route[3][4:0] == 5'h00 && route[5] == 16'h0000 &&
		                               (VARIANT == ROS_VAR_SMALL_MC || route[6] == 16'h0000)))
		else $error("absent field holds data");
	a_port_ctrl: assert property (
		@(posedge clk) disable iff (sys_rst) (pinCode[4:0] == CODE_PORT) |-> (pinOut[0] == portOut[0]))
		else $error("code zero did not give port control");
	a_unmapped_read: assert property (
		@(posedge clk) disable iff (sys_rst)
		(clkEn && addrValid && !ahbReq.hwrite && !mapped) |=> rdData == 32'h00000000)
		else $error("unmapped read nonzero");

	c_write: cover property (@(posedge clk) clkEn && wrPend && wrHit);
	c_read: cover property (@(posedge clk) clkEn && addrValid && !ahbReq.hwrite && mapped);
	c_routed: cover property (@(posedge clk) pinRouted[15]);
	c_unmapped: cover property (@(posedge clk) addrValid && !mapped);
endmodule : ros_out_select

// ---- logic/ros_pin_mux.sv ----
`timescale 1ns/1ns
module ros_pin_mux
	import ros_pkg::*;
(
	input  wire logic [NUM_PINS*CODE_W-1:0] pinCode,
	input  wire logic [NUM_FUNCS-1:0]       periphOut,
	input  wire logic [NUM_PINS-1:0]        portOut,
	output logic      [NUM_PINS-1:0]        pinOut,
	output logic      [NUM_PINS-1:0]        pinRouted
);
	function automatic logic codeRoutes(input logic [4:0] code);
		codeRoutes = (code != CODE_PORT) && (code <= CODE_MAX_ASSIGNED);
	endfunction : codeRoutes

	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		wire logic [4:0] code = pinCode[p*CODE_W +: CODE_W];
		// Zero and unassigned codes leave the pin with its port latch.
		assign pinRouted[p] = codeRoutes(code);
		assign pinOut[p]    = pinRouted[p] ? periphOut[code] : portOut[p];
	end
endmodule : ros_pin_mux

// ---- logic/ros_pkg.sv ----
package ros_pkg;

	// Device variants select which selector fields exist.
	typedef enum logic [1:0] {
		ROS_VAR_FULL,
		ROS_VAR_SMALL_GP,
		ROS_VAR_SMALL_MC
	} ros_variant_t;

	localparam int NUM_REGS   = 8;
	localparam int NUM_PINS   = 16;
	localparam int CODE_W     = 5;
	localparam int NUM_FUNCS  = 32;

	// Printed offsets, which are not all multiples of four, are kept as word indices (haddr >> 2).
	localparam logic [11:0] OUT_ROUTE_PINS_0_1   = 12'h6c0;
	localparam logic [11:0] OUT_ROUTE_PINS_2_3   = 12'h6c2;
	localparam logic [11:0] OUT_ROUTE_PINS_4_5   = 12'h6c4;
	localparam logic [11:0] OUT_ROUTE_PINS_6_7   = 12'h6c6;
	localparam logic [11:0] OUT_ROUTE_PINS_8_9   = 12'h6c8;
	localparam logic [11:0] OUT_ROUTE_PINS_10_11 = 12'h6ca;
	localparam logic [11:0] OUT_ROUTE_PINS_12_13 = 12'h6cc;
	localparam logic [11:0] OUT_ROUTE_PINS_14_15 = 12'h6ce;
	localparam logic [11:0] REG_STRIDE           = 12'h002;

	localparam int EVEN_LSB = 0;
	localparam int ODD_LSB  = 8;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [4:0]  CODE_PORT = 5'h00;

	// Highest function code that names a peripheral; codes above it act as port control.
	localparam logic [4:0]  CODE_MAX_ASSIGNED = 5'h1f;

	// Per-register field presence for each variant: bit 2n marks register n's even field, bit 2n+1 its odd field.
	localparam logic [15:0] FIELDS_FULL     = 16'hffff;
	localparam logic [15:0] FIELDS_SMALL_GP = 16'hc393;
	localparam logic [15:0] FIELDS_SMALL_MC = 16'hf393;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
		logic        hready;
	} ros_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ros_ahb_rsp_t;

endpackage : ros_pkg

// ---- tb/ros_out_select_bench.sv ----
`timescale 1ns/1ns
module ros_out_select_bench;
	import ros_pkg::*;
	logic                 clk = 1'b0;
	logic                 sysRst;
	logic [31:0]          haddr, hwdata, rd;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic                 clkEn;
	logic                 rsp;
	logic [31:0]          rdGp, rdMc;
	ros_ahb_req_t         ahbReq;
	ros_ahb_rsp_t         ahbRsp;
	ros_ahb_rsp_t         rspGp, rspMc;
	logic [NUM_FUNCS-1:0] periphOut;
	logic [NUM_PINS-1:0]  portOut, pinOut, pinRouted;
	int                   badCount = 0;
	int                   numChecks = 0;
	always #25 clk = ~clk;
	assign ahbReq = {haddr, htrans, hwrite, 3'b010, 1'b1, ahbRsp.hreadyout};
	ros_periph_model i_ros_periph_model (.clk(clk), .periphOut(periphOut), .portOut(portOut));
	ros_out_select i_ros_out_select (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .ahbReq(ahbReq),
		.hwdata(hwdata), .ahbRsp(ahbRsp), .periphOut(periphOut), .portOut(portOut),
		.pinOut(pinOut), .pinRouted(pinRouted));
	// The small variants share the bus and answer every access alongside the full one.
	ros_out_select #(.VARIANT(ROS_VAR_SMALL_GP)) i_ros_out_select_gp (.clk(clk), .sys_rst(sysRst),
		.clkEn(clkEn), .ahbReq(ahbReq), .hwdata(hwdata), .ahbRsp(rspGp), .periphOut(periphOut),
		.portOut(portOut), .pinOut(), .pinRouted());
	ros_out_select #(.VARIANT(ROS_VAR_SMALL_MC)) i_ros_out_select_mc (.clk(clk), .sys_rst(sysRst),
		.clkEn(clkEn), .ahbReq(ahbReq), .hwdata(hwdata), .ahbRsp(rspMc), .periphOut(periphOut),
		.portOut(portOut), .pinOut(), .pinRouted());
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : printVerdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One single word transfer; each phase is held until hready is seen high.
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
		rd = ahbRsp.hrdata;
		rdGp = rspGp.hrdata;
		rdMc = rspMc.hrdata;
		rsp = ahbRsp.hresp;
	endtask : xfer
	task automatic rdChk(input logic [31:0] a, input logic [15:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, {16'h0, exp});
		chk({31'h0, rsp}, 32'h0);
	endtask : rdChk
	// Implemented selector bits of register n in the small variants.
	function automatic logic [15:0] expMask(input int n, input logic mc);
		case (n)
			0, 4, 7: return 16'h1f1f;
			2: return 16'h001f;
			3: return 16'h1f00;
			6: return mc ? 16'h1f1f : 16'h0000;
			default: return 16'h0000;
		endcase
	endfunction : expMask
	function automatic logic [31:0] ra(input int n);
		return 32'(4 * (OUT_ROUTE_PINS_0_1 + REG_STRIDE * n));
	endfunction : ra
	initial begin
		logic [4:0] e, o;
		sysRst = 1'b1; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0; clkEn = 1'b1;
		repeat (20) @(posedge clk);
		sysRst <= 1'b0;
		for (int n = 0; n < 8; n++) begin
			rdChk(ra(n), REG_RESET);
			chk(rdGp, 32'h0);
			chk(rdMc, 32'h0);
		end
		$display("reset values done");
		for (int n = 0; n < 8; n++) begin
			xfer(1'b1, ra(n), 32'hffffffff);
			rdChk(ra(n), 16'h1f1f);
			chk(rdGp, {16'h0, expMask(n, 1'b0)});
			chk(rdMc, {16'h0, expMask(n, 1'b1)});
		end
		xfer(1'b1, ra(0) + 4, 32'h0);
		rdChk(ra(0) + 4, 16'h0);
		rdChk(ra(0), 16'h1f1f);
		clkEn <= 1'b0;
		xfer(1'b1, ra(0), 32'h0);
		clkEn <= 1'b1;
		rdChk(ra(0), 16'h1f1f);
		$display("register access done");
		for (int c = 0; c < 32; c++) begin
			e = c[4:0];
			o = ~e;
			xfer(1'b1, ra(3), {16'h0, 3'h0, o, 3'h0, e});
			rdChk(ra(3), {3'h0, o, 3'h0, e});
			@(negedge clk);
			chk({28'h0, pinRouted[7:6], pinOut[7:6]}, {28'h0, o != 0, e != 0,
				(o != 0) ? periphOut[o] : portOut[7], (e != 0) ? periphOut[e] : portOut[6]});
			@(posedge clk);
		end
		$display("routing codes done");
		sysRst <= 1'b1;
		@(posedge clk);
		sysRst <= 1'b0;
		rdChk(ra(3), REG_RESET);
		rdChk(ra(7), REG_RESET);
		$display("second reset done");
		printVerdict();
	end
	initial begin
		#(50 * 20000);
		badCount++;
		printVerdict();
	end
endmodule : ros_out_select_bench

// ---- tb/ros_periph_model.sv ----
`timescale 1ns/1ns
module ros_periph_model
	import ros_pkg::*;
(
	input  wire logic                         clk,
	output logic      [ros_pkg::NUM_FUNCS-1:0] periphOut,
	output logic      [ros_pkg::NUM_PINS-1:0]  portOut
);
	// Both sources change every cycle, so a stale or wrong route cannot match by luck.
	initial begin
		periphOut = 32'h9c5a36e1;
		portOut   = 16'h4b2d;
	end
	always @(posedge clk) begin
		periphOut <= {periphOut[30:0], ~periphOut[31]};
		portOut   <= ~portOut;
	end
endmodule : ros_periph_model
